/* File: core/channel_format_decoder_regs.svh */
`ifndef CHANNEL_FORMAT_DECODER_REGS_SVH
`define CHANNEL_FORMAT_DECODER_REGS_SVH
// field positions
`define F32_SIGN 31
`define F32_EXP_LSB 23
`define F64_SIGN 63
`define F64_EXP_LSB 52
`define F16_SIGN 15
`define F16_EXP_LSB 10
`define F11_EXP_LSB 6
`define F10_EXP_LSB 5
`define SHR_EXP_LSB 27
`define SHR_BLUE_LSB 18
`define SHR_GREEN_LSB 9
`define SHR_RED_LSB 0
`define SHR_FRAC_W 9
// exponent tops and biases
`define F32_EXP_TOP 11'h0FF
`define F64_EXP_TOP 11'h7FF
`define SML_EXP_TOP 11'h01F
`define F32_BIAS 16'sh007F
`define F64_BIAS 16'sh03FF
`define SML_BIAS 16'sh000F
// f32 scale of a raw significand: bias plus fraction width
`define F32_SIG_OFS 16'sh0096
// fraction bits of the signed normalized reciprocal series
`define NRM_FIX_W 48
// constant encodings
`define F32_ONE 32'h3F800000
`define F32_NEG_ONE 32'hBF800000
`define F32_HALF 32'h3F000000
`define F32_INF 32'h7F800000
`define F32_QNAN 32'h7FC00000
`define F16_ONE 16'h3C00
`define F16_INF 16'h7C00
`define F16_QNAN 16'h7E00
// reset value of the result state
`define DEC_RESET '0
`endif

/* File: core/cfd_pkg.sv */
package cfd_pkg;
	typedef enum logic [3:0] {
		FmtSgnNorm, FmtUnsInt, FmtUnsScl, FmtSgnInt, FmtSgnScl,
		FmtF32, FmtF64, FmtF16, FmtF11, FmtF10, FmtShared, FmtNarrow
	} fmt_t;

	typedef struct packed {
		logic valid;
		logic [63:0] data;
		logic isFloat;
		logic sign;
		logic nan;
		logic inf;
		logic zero;
		logic denorm;
		logic signed [11:0] expo;
		logic [31:0] green;
		logic [31:0] blue;
		logic [15:0] store;
	} dec_state_t;
endpackage

/* File: core/fp_round_pack.sv */
module fp_round_pack #(
	parameter int EXPW = 8,
	parameter int FRACW = 23
) (
	// value is mag times two to the scale
	input wire logic [63:0] mag,
	input wire logic signed [15:0] scale,
	input wire logic sign,
	// packed float, round to nearest even
	output logic [EXPW+FRACW:0] fpOut
);
	localparam int BIAS = (1 << (EXPW - 1)) - 1;
	localparam int EMIN = 1 - BIAS;
	localparam int ETOP = (1 << EXPW) - 1;

	always_comb begin
		int msb;
		int expo;
		int sh;
		int biased;
		logic [63:0] kept;
		logic rnd;
		logic sticky;
		msb = 0;
		kept = 64'h0;
		for (int i = 0; i < 64; i++) begin
			if (mag[i]) begin
				msb = i;
			end
		end
		expo = msb + int'(scale);
		// below the normal range the lsb is pinned, giving denormals
		sh = (expo >= EMIN) ? msb - FRACW : EMIN - FRACW - int'(scale);
		rnd = 1'b0;
		sticky = 1'b0;
		biased = 0;
		if (sh <= 0) begin
			kept = mag << (-sh);
		end else if (sh > 64) begin
			kept = 64'h0;
			sticky = |mag;
		end else begin
			kept = mag >> sh;
			rnd = mag[sh-1];
			sticky = |(mag & ((64'h1 << (sh - 1)) - 64'h1));
		end
		kept = kept + {63'h0, rnd & (sticky | kept[0])};
		if (mag == 64'h0) begin
			fpOut = {sign, {(EXPW + FRACW){1'b0}}};
		end else if (expo >= EMIN) begin
			biased = expo + BIAS + (kept[FRACW+1] ? 1 : 0);
			if (biased >= ETOP) begin
				fpOut = {sign, {EXPW{1'b1}}, {FRACW{1'b0}}};
			end else begin
				fpOut = {sign, EXPW'(biased), kept[FRACW-1:0]};
			end
		end else begin
			// a carry into the hidden bit lands on the least normal exponent
			fpOut = {sign, {(EXPW - 1){1'b0}}, kept[FRACW], kept[FRACW-1:0]};
		end
	end
endmodule

/* File: core/channel_format_decoder.sv */
`include "channel_format_decoder_regs.svh"

// Behaviour
// RL1: signed normalized scales by two-to-n-minus-one less one
// RL2: most negative signed normalized code gives minus one
// RL3: unsigned integer passes through zero-extended
// RL4: unsigned scaled becomes float, nearest even
// RL5: signed integer passes through sign-extended
// RL6: signed scaled becomes float, nearest even
// RL7: f32 fields; all-ones exponent gives NaN or infinity
// RL8: f32 bias 127, denormal scale minus 126
// RL9: f64 fields, bias 1023, specials on all-ones
// RL10: f16 fields, bias 15, exponent 31 special
// RL11: f32 to f16 rounds to nearest even
// RL12: unsigned f11 and f10, bias 15, positive infinity
// RL13: shared exponent: three 9-bit fractions, 0.f scaling
// RL14: shared exponent never signed, infinite or NaN
// RL15: pixel bytes are little-endian in address order
// RL16: channels sit least significant first in pixel
// RL17: f16 narrowing overflows to infinity, underflows to denormal
// RL18: requester gives a format with every word
module channel_format_decoder (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// request
	input wire logic inValid,
	input wire cfd_pkg::fmt_t fmtSel,
	input wire logic [5:0] chanLsb,
	input wire logic [5:0] chanWidth,
	input wire logic [7:0] memByte [8],
	// result
	output logic outValid,
	output logic [63:0] outData,
	output logic outIsFloat,
	output logic outSign,
	output logic outNan,
	output logic outInf,
	output logic outZero,
	output logic outDenorm,
	output logic signed [11:0] outExp,
	output logic [31:0] outGreen,
	output logic [31:0] outBlue,
	output logic [7:0] storeByte [2]
);
	logic [63:0] pixel;
	logic [63:0] chanShift;
	logic [63:0] lowMask;
	logic [63:0] chanRaw;
	logic [63:0] chanSx;
	logic [63:0] absChan;
	logic chanNeg;
	logic mostNeg;
	logic [63:0] convMag;
	logic signed [15:0] convScale;
	logic convSign;
	logic [31:0] f32Conv;
	logic [4:0] smallE;
	logic [9:0] smallF;
	logic [3:0] smallW;
	logic [7:0] narExp;
	logic [63:0] narMag;
	logic signed [15:0] narScale;
	logic [15:0] narOut;
	cfd_pkg::dec_state_t stateD;
	cfd_pkg::dec_state_t stateQ;

	function automatic logic [63:0] widthMask(input logic [5:0] n);
		return (n >= 6'h20) ? 64'h00000000FFFFFFFF : (64'h1 << n) - 64'h1;
	endfunction

	function automatic logic [3:0] classify(input logic [10:0] e, input logic [10:0] top,
		input logic fracNz);
		return {e == top && fracNz, e == top && !fracNz, e == 11'h0 && !fracNz,
			e == 11'h0 && fracNz};
	endfunction

	function automatic logic signed [11:0] unbiased(input logic [10:0] e,
		input logic signed [15:0] bias);
		logic signed [15:0] v;
		v = (e == 11'h0) ? 16'sh0001 - bias : $signed({5'h0, e}) - bias;
		return $signed(v[11:0]);
	endfunction

	// truncated series for 1/(2^m-1); exact at the ends, otherwise within an ulp
	function automatic logic [63:0] nrmFixed(input logic [63:0] mag, input logic [5:0] m);
		logic [63:0] acc;
		acc = 64'h0;
		for (int k = 1; k <= `NRM_FIX_W; k++) begin
			if (m != 6'h0 && k * int'(m) <= `NRM_FIX_W) begin
				acc = acc + (mag << (`NRM_FIX_W - k * int'(m)));
			end
		end
		return acc;
	endfunction

	function automatic logic [31:0] sharedChan(input logic [8:0] f, input logic [4:0] e);
		int p;
		logic [31:0] sig;
		p = 0;
		for (int i = 0; i < `SHR_FRAC_W; i++) begin
			if (f[i]) begin
				p = i;
			end
		end
		sig = {23'h0, f} << (23 - p);
		if (f == 9'h0) begin
			return 32'h0;
		end
		return {1'b0, 8'(p + int'(e) - int'(`SML_BIAS) - `SHR_FRAC_W + int'(`F32_BIAS)),
			sig[22:0]};
	endfunction

	for (genvar g = 0; g < 8; g++) begin : gFetch
		assign pixel[8*g+:8] = memByte[g]; // RL15
	end
	for (genvar g = 0; g < 2; g++) begin : gStore
		assign storeByte[g] = stateQ.store[8*g+:8]; // RL15
	end

	assign chanShift = pixel >> chanLsb; // RL16
	assign lowMask = widthMask(chanWidth);
	assign chanRaw = chanShift & lowMask;
	assign chanNeg = (chanWidth != 6'h0) && chanRaw[chanWidth-6'h1];
	assign chanSx = chanNeg ? (chanRaw | ~lowMask) : chanRaw;
	assign absChan = chanNeg ? (~chanSx + 64'h1) : chanSx;
	assign mostNeg = chanNeg && ((chanRaw & (lowMask >> 1)) == 64'h0);

	assign narExp = chanShift[`F32_EXP_LSB+:8];
	assign narMag = {40'h0, narExp != 8'h0, chanShift[22:0]};
	assign narScale = $signed({8'h0, (narExp == 8'h0) ? 8'h01 : narExp}) - `F32_SIG_OFS;

	always_comb begin
		convMag = 64'h0;
		convScale = 16'sh0000;
		convSign = 1'b0;
		smallE = 5'h0;
		smallF = 10'h0;
		smallW = 4'h0;
		unique case (fmtSel)
			cfd_pkg::FmtSgnNorm: begin
				convSign = chanNeg;
				convMag = nrmFixed(absChan, chanWidth - 6'h1); // RL1
				convScale = -16'sd`NRM_FIX_W;
			end
			cfd_pkg::FmtUnsScl: begin
				convMag = chanRaw; // RL4
			end
			cfd_pkg::FmtSgnScl: begin
				convSign = chanNeg; // RL6
				convMag = absChan;
			end
			cfd_pkg::FmtF16: begin
				smallE = chanShift[`F16_EXP_LSB+:5]; // RL10
				smallF = chanShift[9:0];
				smallW = 4'hA;
				convSign = chanShift[`F16_SIGN];
			end
			cfd_pkg::FmtF11: begin
				smallE = chanShift[`F11_EXP_LSB+:5]; // RL12
				smallF = {4'h0, chanShift[5:0]};
				smallW = 4'h6;
			end
			cfd_pkg::FmtF10: begin
				smallE = chanShift[`F10_EXP_LSB+:5]; // RL12
				smallF = {5'h0, chanShift[4:0]};
				smallW = 4'h5;
			end
			default: begin
			end
		endcase
		// small floats widen exactly to f32, so the rounder never rounds them
		if (smallW != 4'h0) begin
			convMag = {54'h0, smallF} | ((smallE != 5'h0) ? (64'h1 << smallW) : 64'h0);
			convScale = $signed({11'h0, (smallE == 5'h0) ? 5'h01 : smallE}) - `SML_BIAS
				- $signed({12'h0, smallW});
		end
	end

	fp_round_pack #(.EXPW(8), .FRACW(23)) toSingle (
		.mag(convMag),
		.scale(convScale),
		.sign(convSign),
		.fpOut(f32Conv)
	);

	fp_round_pack #(.EXPW(5), .FRACW(10)) toHalf (
		.mag(narMag),
		.scale(narScale),
		.sign(chanShift[`F32_SIGN]),
		.fpOut(narOut)
	);

	always_comb begin
		stateD = `DEC_RESET;
		stateD.valid = inValid;
		unique case (fmtSel)
			cfd_pkg::FmtSgnNorm: begin
				stateD.isFloat = 1'b1;
				stateD.sign = chanNeg;
				if (mostNeg) begin
					stateD.data = {32'h0, `F32_NEG_ONE}; // RL2
				end else if (chanRaw == 64'h0) begin
					stateD.zero = 1'b1;
				end else if (absChan == (lowMask >> 1)) begin
					stateD.data = {32'h0, chanNeg ? `F32_NEG_ONE : `F32_ONE}; // RL1
				end else begin
					stateD.data = {32'h0, f32Conv}; // RL1
				end
			end
			cfd_pkg::FmtUnsInt: begin
				stateD.data = chanRaw; // RL3
			end
			cfd_pkg::FmtSgnInt: begin
				stateD.data = chanSx; // RL5
			end
			cfd_pkg::FmtUnsScl, cfd_pkg::FmtSgnScl: begin
				stateD.isFloat = 1'b1;
				stateD.sign = convSign;
				stateD.zero = chanRaw == 64'h0;
				stateD.data = {32'h0, f32Conv}; // RL4 RL6
			end
			cfd_pkg::FmtF32, cfd_pkg::FmtNarrow: begin
				stateD.isFloat = 1'b1;
				stateD.sign = chanShift[`F32_SIGN];
				{stateD.nan, stateD.inf, stateD.zero, stateD.denorm} =
					classify({3'h0, narExp}, `F32_EXP_TOP, |chanShift[22:0]); // RL7
				stateD.expo = unbiased({3'h0, narExp}, `F32_BIAS); // RL8
				stateD.data = {32'h0, chanShift[31:0]};
				if (fmtSel == cfd_pkg::FmtNarrow) begin
					if (stateD.nan) begin
						stateD.data = {48'h0, `F16_QNAN | {stateD.sign, 15'h0}};
					end else if (stateD.inf) begin
						stateD.data = {48'h0, `F16_INF | {stateD.sign, 15'h0}};
					end else begin
						stateD.data = {48'h0, narOut}; // RL11 RL17
					end
				end
			end
			cfd_pkg::FmtF64: begin
				stateD.isFloat = 1'b1;
				stateD.sign = chanShift[`F64_SIGN];
				{stateD.nan, stateD.inf, stateD.zero, stateD.denorm} =
					classify(chanShift[`F64_EXP_LSB+:11], `F64_EXP_TOP, |chanShift[51:0]); // RL9
				stateD.expo = unbiased(chanShift[`F64_EXP_LSB+:11], `F64_BIAS); // RL9
				stateD.data = chanShift;
			end
			cfd_pkg::FmtF16, cfd_pkg::FmtF11, cfd_pkg::FmtF10: begin
				stateD.isFloat = 1'b1;
				stateD.sign = convSign;
				{stateD.nan, stateD.inf, stateD.zero, stateD.denorm} =
					classify({6'h0, smallE}, `SML_EXP_TOP, smallF != 10'h0); // RL10 RL12
				stateD.expo = unbiased({6'h0, smallE}, `SML_BIAS);
				if (stateD.nan) begin
					stateD.data = {32'h0, `F32_QNAN};
				end else if (stateD.inf) begin
					stateD.data = {32'h0, `F32_INF | {convSign, 31'h0}};
				end else begin
					stateD.data = {32'h0, f32Conv};
				end
			end
			cfd_pkg::FmtShared: begin
				stateD.isFloat = 1'b1;
				stateD.zero = chanShift[26:0] == 27'h0; // RL14
				stateD.data = {32'h0, sharedChan(chanShift[`SHR_RED_LSB+:9],
					chanShift[`SHR_EXP_LSB+:5])}; // RL13
				stateD.green = sharedChan(chanShift[`SHR_GREEN_LSB+:9], chanShift[`SHR_EXP_LSB+:5]);
				stateD.blue = sharedChan(chanShift[`SHR_BLUE_LSB+:9], chanShift[`SHR_EXP_LSB+:5]);
			end
			default: begin
			end
		endcase
		stateD.store = stateD.data[15:0]; // RL15
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			stateQ <= `DEC_RESET;
		end else begin
			stateQ <= stateD;
		end
	end

	assign outValid = stateQ.valid;
	assign outData = stateQ.data;
	assign outIsFloat = stateQ.isFloat;
	assign outSign = stateQ.sign;
	assign outNan = stateQ.nan;
	assign outInf = stateQ.inf;
	assign outZero = stateQ.zero;
	assign outDenorm = stateQ.denorm;
	assign outExp = stateQ.expo;
	assign outGreen = stateQ.green;
	assign outBlue = stateQ.blue;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	AST_NORM_ONE: assert property ( // RL1
		inValid && fmtSel == cfd_pkg::FmtSgnNorm && !chanNeg && chanRaw != 64'h0
		&& chanRaw == (lowMask >> 1) |=> outData[31:0] == `F32_ONE)
		else $error("positive full scale did not give one");
	AST_NORM_CLAMP: assert property ( // RL2
		inValid && fmtSel == cfd_pkg::FmtSgnNorm && mostNeg |=> outData[31:0] == `F32_NEG_ONE)
		else $error("most negative code not clamped");
	AST_UNSIGNED_INTEGER_ZX: assert property ( // RL3
		inValid && fmtSel == cfd_pkg::FmtUnsInt |=> outData == $past(chanRaw) && !outIsFloat)
		else $error("unsigned integer not zero extended");
	AST_USCL_RNE: assert property ( // RL4
		inValid && fmtSel == cfd_pkg::FmtUnsScl && chanRaw == 64'h01000001
		|=> outData[31:0] == 32'h4B800000 && outIsFloat)
		else $error("unsigned scaled tie not rounded to even");
	AST_SIGNED_INTEGER_SX: assert property ( // RL5
		inValid && fmtSel == cfd_pkg::FmtSgnInt && chanNeg |=> outData[63] && !outIsFloat)
		else $error("signed integer not sign extended");
	AST_SSCL_NEG: assert property ( // RL6
		inValid && fmtSel == cfd_pkg::FmtSgnScl && chanSx == 64'hFFFFFFFFFFFFFFFF
		|=> outData[31:0] == `F32_NEG_ONE)
		else $error("signed scaled minus one wrong");
	AST_F32_SPECIAL: assert property ( // RL7
		inValid && fmtSel == cfd_pkg::FmtF32 && narExp == 8'hFF
		|=> outNan == $past(chanShift[22:0] != 23'h0) && outInf != outNan)
		else $error("f32 special class wrong");
	AST_F32_DENORM: assert property ( // RL8
		inValid && fmtSel == cfd_pkg::FmtF32 && narExp == 8'h0 && chanShift[22:0] != 23'h0
		|=> outDenorm && outExp == 12'shF82)
		else $error("f32 denormal scale wrong");
	AST_F64_SPECIAL: assert property ( // RL9
		inValid && fmtSel == cfd_pkg::FmtF64 && chanShift[62:52] == 11'h7FF
		|=> (outNan || outInf) && outSign == $past(chanShift[63]))
		else $error("f64 special class wrong");
	AST_F16_INF: assert property ( // RL10
		inValid && fmtSel == cfd_pkg::FmtF16 && chanShift[14:0] == 15'h7C00
		|=> outInf && outData[30:0] == 31'h7F800000 && outSign == $past(chanShift[15]))
		else $error("f16 infinity wrong");
	AST_NARROW_RNE: assert property ( // RL11
		inValid && fmtSel == cfd_pkg::FmtNarrow && chanShift[31:0] == 32'h3F801000
		|=> outData[15:0] == `F16_ONE && storeByte[1] == 8'h3C)
		else $error("f16 narrowing tie not rounded to even");
	AST_SMALL_UNSIGNED: assert property ( // RL12
		inValid && (fmtSel == cfd_pkg::FmtF11 || fmtSel == cfd_pkg::FmtF10)
		|=> !outSign && !outData[31])
		else $error("unsigned small float produced a sign");
	AST_SHARED_HALF: assert property ( // RL13
		inValid && fmtSel == cfd_pkg::FmtShared && chanShift[31:27] == 5'h0F
		&& chanShift[8:0] == 9'h100 |=> outData[31:0] == `F32_HALF)
		else $error("shared exponent scaling wrong");
	AST_SHARED_POS: assert property ( // RL14
		inValid && fmtSel == cfd_pkg::FmtShared
		|=> !outNan && !outInf && !outData[31] && !outGreen[31] && !outBlue[31])
		else $error("shared exponent gave sign or special");
	AST_BYTE_ORDER: assert property ( // RL15
		inValid && fmtSel == cfd_pkg::FmtUnsInt && chanLsb == 6'h0 && chanWidth == 6'h10
		|=> outData[15:0] == {$past(memByte[1]), $past(memByte[0])})
		else $error("pixel bytes not little endian");
	AST_CHAN_PLACE: assert property ( // RL16
		inValid && fmtSel == cfd_pkg::FmtUnsInt && chanLsb == 6'h08 && chanWidth == 6'h08
		|=> outData == {56'h0, $past(memByte[1])})
		else $error("channel not taken from its position");
	AST_NARROW_RANGE: assert property ( // RL17
		inValid && fmtSel == cfd_pkg::FmtNarrow && narExp > 8'h8E && narExp != 8'hFF
		|=> outData[14:0] == 15'h7C00 && outData[15] == $past(chanShift[`F32_SIGN]))
		else $error("f16 overflow not infinity");
	AST_NARROW_TINY: assert property ( // RL17
		inValid && fmtSel == cfd_pkg::FmtNarrow && narExp < 8'h66 |=> outData[14:0] == 15'h0)
		else $error("f16 underflow not zero");

	COV_NORM: cover property (inValid && fmtSel == cfd_pkg::FmtSgnNorm && mostNeg ##1 outValid);
	COV_NARROW: cover property (inValid && fmtSel == cfd_pkg::FmtNarrow ##1 outValid);
	COV_SHARED: cover property (inValid && fmtSel == cfd_pkg::FmtShared ##1 outValid);
	COV_F16_NAN: cover property (inValid && fmtSel == cfd_pkg::FmtF16 ##1 outNan);
endmodule

/* File: tb/pixel_source.sv */
module pixel_source (
	// clock
	input wire logic mclk,
	// request toward the decoder
	output logic inValid,
	output cfd_pkg::fmt_t fmtSel,
	output logic [5:0] chanLsb,
	output logic [5:0] chanWidth,
	output logic [7:0] memByte [8]
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [63:0] lastPix;

	initial begin
		inValid = 1'b0;
		fmtSel = cfd_pkg::FmtUnsInt;
		chanLsb = 6'h00;
		chanWidth = 6'h20;
		lastPix = 64'h0;
		for (int i = 0; i < 8; i++) begin
			memByte[i] = 8'h00;
		end
	end

	// one word per edge; two calls in a row stream back to back
	task automatic send(input logic [3:0] fmt, input logic [5:0] lsb, input logic [5:0] w,
		input logic [63:0] pix);
		@(posedge mclk);
		inValid <= 1'b1;
		fmtSel <= cfd_pkg::fmt_t'(fmt);
		chanLsb <= lsb;
		chanWidth <= w;
		lastPix = pix;
		for (int i = 0; i < 8; i++) begin
			memByte[i] <= pix[8*i +: 8];
		end
	endtask

	// released bytes show the inverse, so a stale copy is never mistaken for data
	task automatic idle();
		@(posedge mclk);
		inValid <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			memByte[i] <= ~lastPix[8*i +: 8];
		end
	endtask
endmodule

/* File: tb/channel_format_decoder_test.sv */
module channel_format_decoder_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk;
	logic sys_rst;
	logic inValid;
	cfd_pkg::fmt_t fmtSel;
	logic [5:0] chanLsb;
	logic [5:0] chanWidth;
	logic [7:0] memByte [8];
	logic outValid, outIsFloat, outSign, outNan, outInf, outZero, outDenorm;
	logic [63:0] outData;
	logic signed [11:0] outExp;
	logic [31:0] outGreen;
	logic [31:0] outBlue;
	logic [7:0] storeByte [2];
	int n_fail;
	int n_tests;
	logic [3:0] curFmt;
	logic [5:0] curLsb;
	logic [5:0] curW;
	logic [5:0] curMask;

	channel_format_decoder channel_format_decoder_inst (.mclk(mclk), .sys_rst(sys_rst),
		.inValid(inValid), .fmtSel(fmtSel), .chanLsb(chanLsb), .chanWidth(chanWidth),
		.memByte(memByte), .outValid(outValid), .outData(outData), .outIsFloat(outIsFloat),
		.outSign(outSign), .outNan(outNan), .outInf(outInf), .outZero(outZero),
		.outDenorm(outDenorm), .outExp(outExp), .outGreen(outGreen), .outBlue(outBlue),
		.storeByte(storeByte));
	pixel_source pixel_source_inst (.mclk(mclk), .inValid(inValid), .fmtSel(fmtSel),
		.chanLsb(chanLsb), .chanWidth(chanWidth), .memByte(memByte));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic cmpVal(input string name, input logic [63:0] exp, input logic [63:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic cmpFlags(input string name, input logic [5:0] exp, input logic [5:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %b seen %b", name, exp, got);
		end
	endtask

	task automatic setup(input logic [3:0] f, input logic [5:0] l, input logic [5:0] w,
		input logic [5:0] m);
		curFmt = f;
		curLsb = l;
		curW = w;
		curMask = m;
	endtask

	// flags are {float, sign, nan, inf, zero, denorm}; exponent 800 means not checked
	task automatic judge(input logic [63:0] eData, input logic [5:0] eFl, input logic [11:0] eExp);
		logic [5:0] fl;
		fl = {outIsFloat, outSign, outNan, outInf, outZero, outDenorm};
		cmpVal("valid", 64'h1, {63'h0, outValid});
		cmpVal("data", eData, outData);
		cmpVal("store", {48'h0, eData[15:0]}, {48'h0, storeByte[1], storeByte[0]});
		cmpFlags("flags", eFl & curMask, fl & curMask);
		if (eExp !== 12'h800) begin
			cmpVal("exp", {52'h0, eExp}, {52'h0, outExp});
		end
	endtask

	task automatic xfer(input logic [63:0] pix, input logic [63:0] eData, input logic [5:0] eFl,
		input logic [11:0] eExp);
		pixel_source_inst.send(curFmt, curLsb, curW, pix);
		pixel_source_inst.idle();
		#1;
		judge(eData, eFl, eExp);
	endtask

	task automatic test_reset_and_illegal();
		sys_rst = 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		cmpVal("reset valid", 64'h0, {63'h0, outValid});
		cmpVal("reset data", 64'h0, outData);
		repeat (7) @(posedge mclk);
		sys_rst <= 1'b0;
		setup(4'hC, 6'h00, 6'h10, 6'h3F);
		xfer(64'hFFFF_FFFF_FFFF_FFFF, 64'h0, 6'h00, 12'h000);
		pixel_source_inst.idle();
		#1;
		cmpVal("idle valid", 64'h0, {63'h0, outValid});
		cmpVal("idle data", 64'h0, outData);
	endtask

	task automatic test_int();
		setup(4'h1, 6'h00, 6'h10, 6'h3F);
		xfer(64'h0000_0000_0000_1234, 64'h1234, 6'h00, 12'h800);
		setup(4'h1, 6'h10, 6'h10, 6'h3F);
		xfer(64'hFFFF_FFFF_ABCD_1234, 64'hABCD, 6'h00, 12'h800);
		setup(4'h1, 6'h00, 6'h20, 6'h3F);
		xfer(64'h5555_5555_FFFF_FFFF, 64'hFFFF_FFFF, 6'h00, 12'h800);
		setup(4'h1, 6'h08, 6'h08, 6'h3F);
		xfer(64'h0000_0000_0000_A55A, 64'hA5, 6'h00, 12'h800);
		setup(4'h3, 6'h08, 6'h10, 6'h3F);
		xfer(64'h0000_0000_00FF_FD00, 64'hFFFF_FFFF_FFFF_FFFD, 6'h00, 12'h800);
		setup(4'h3, 6'h04, 6'h04, 6'h3F);
		xfer(64'h0000_0000_0000_0080, 64'hFFFF_FFFF_FFFF_FFF8, 6'h00, 12'h800);
		setup(4'h3, 6'h00, 6'h20, 6'h3F);
		xfer(64'hFFFF_FFFF_7FFF_FFFF, 64'h7FFF_FFFF, 6'h00, 12'h800);
	endtask

	task automatic test_scaled();
		setup(4'h2, 6'h00, 6'h08, 6'h3F);
		xfer(64'h03, 64'h4040_0000, 6'h20, 12'h800);
		setup(4'h2, 6'h00, 6'h20, 6'h3F);
		xfer(64'hFFFF_FFFF, 64'h4F80_0000, 6'h20, 12'h800);
		xfer(64'h0100_0001, 64'h4B80_0000, 6'h20, 12'h800);
		xfer(64'h0100_0003, 64'h4B80_0002, 6'h20, 12'h800);
		setup(4'h4, 6'h00, 6'h10, 6'h3F);
		xfer(64'hFFFD, 64'hC040_0000, 6'h30, 12'h800);
		setup(4'h4, 6'h00, 6'h20, 6'h3F);
		xfer(64'h8000_0000, 64'hCF00_0000, 6'h30, 12'h800);
		xfer(64'hFEFF_FFFF, 64'hCB80_0000, 6'h30, 12'h800);
		xfer(64'hFFFF_FFFF, 64'hBF80_0000, 6'h30, 12'h800);
	endtask

	task automatic test_signed_normalized();
		setup(4'h0, 6'h08, 6'h08, 6'h3F);
		xfer(64'h7F00, 64'h3F80_0000, 6'h20, 12'h800);
		xfer(64'h8100, 64'hBF80_0000, 6'h30, 12'h800);
		xfer(64'h80FF, 64'hBF80_0000, 6'h30, 12'h800);
		xfer(64'hFF00FF, 64'h0, 6'h22, 12'h800);
	endtask

	task automatic test_wide_float();
		setup(4'h5, 6'h00, 6'h20, 6'h3F);
		xfer(64'h3F80_0000, 64'h3F80_0000, 6'h20, 12'h000);
		xfer(64'hFF80_0000, 64'hFF80_0000, 6'h34, 12'h800);
		xfer(64'h7F80_0001, 64'h7F80_0001, 6'h28, 12'h800);
		xfer(64'h0000_0001, 64'h0000_0001, 6'h21, 12'hF82);
		xfer(64'h0080_0000, 64'h0080_0000, 6'h20, 12'hF82);
		xfer(64'h8000_0000, 64'h8000_0000, 6'h32, 12'h800);
		setup(4'h5, 6'h20, 6'h20, 6'h3F);
		xfer(64'h4000_0000_0000_0000, 64'h4000_0000, 6'h20, 12'h001);
		setup(4'h6, 6'h00, 6'h20, 6'h3F);
		xfer(64'h3FF0_0000_0000_0000, 64'h3FF0_0000_0000_0000, 6'h20, 12'h000);
		xfer(64'h7FF0_0000_0000_0000, 64'h7FF0_0000_0000_0000, 6'h24, 12'h800);
		xfer(64'h7FF8_0000_0000_0000, 64'h7FF8_0000_0000_0000, 6'h28, 12'h800);
		xfer(64'h1, 64'h1, 6'h21, 12'hC02);
		xfer(64'h8000_0000_0000_0000, 64'h8000_0000_0000_0000, 6'h32, 12'h800);
	endtask

	task automatic test_small_float();
		setup(4'h7, 6'h00, 6'h10, 6'h3F);
		xfer(64'h3C00, 64'h3F80_0000, 6'h20, 12'h000);
		xfer(64'hFC00, 64'hFF80_0000, 6'h34, 12'h800);
		xfer(64'h7C01, 64'h7FC0_0000, 6'h28, 12'h800);
		xfer(64'h0001, 64'h3380_0000, 6'h21, 12'hFF2);
		xfer(64'hC000, 64'hC000_0000, 6'h30, 12'h001);
		setup(4'h8, 6'h00, 6'h10, 6'h3F);
		xfer(64'h3C0, 64'h3F80_0000, 6'h20, 12'h000);
		xfer(64'hFC0, 64'h7F80_0000, 6'h24, 12'h800);
		xfer(64'h7C1, 64'h7FC0_0000, 6'h28, 12'h800);
		xfer(64'h001, 64'h3580_0000, 6'h21, 12'hFF2);
		setup(4'h9, 6'h00, 6'h10, 6'h3F);
		xfer(64'h5E0, 64'h3F80_0000, 6'h20, 12'h000);
		xfer(64'h3E0, 64'h7F80_0000, 6'h24, 12'h800);
		xfer(64'h3E1, 64'h7FC0_0000, 6'h28, 12'h800);
		xfer(64'h010, 64'h3800_0000, 6'h21, 12'hFF2);
	endtask

	task automatic test_shared();
		setup(4'hA, 6'h00, 6'h20, 6'h1C);
		xfer(64'h7803_FF00, 64'h3F00_0000, 6'h20, 12'h800);
		cmpVal("green", 64'h3F7F_8000, {32'h0, outGreen});
		cmpVal("blue", 64'h0, {32'h0, outBlue});
		xfer(64'hFC00_03FF, 64'h477F_8000, 6'h20, 12'h800);
		cmpVal("green", 64'h4300_0000, {32'h0, outGreen});
		cmpVal("blue", 64'h4700_0000, {32'h0, outBlue});
	endtask

	task automatic test_narrow();
		setup(4'hB, 6'h00, 6'h20, 6'h00);
		xfer(64'h3F80_1000, 64'h3C00, 6'h00, 12'h800);
		xfer(64'h3F80_3000, 64'h3C02, 6'h00, 12'h800);
		xfer(64'h3F80_1001, 64'h3C01, 6'h00, 12'h800);
		xfer(64'h477F_F000, 64'h7C00, 6'h00, 12'h800);
		xfer(64'hC780_0000, 64'hFC00, 6'h00, 12'h800);
		xfer(64'h3380_0000, 64'h0001, 6'h00, 12'h800);
		xfer(64'h3300_0000, 64'h0000, 6'h00, 12'h800);
		xfer(64'h3340_0000, 64'h0001, 6'h00, 12'h800);
		xfer(64'h3880_0000, 64'h0400, 6'h00, 12'h800);
		xfer(64'h8000_0001, 64'h8000, 6'h00, 12'h800);
		xfer(64'hFFC0_0000, 64'hFE00, 6'h00, 12'h800);
	endtask

	task automatic test_back_to_back();
		setup(4'h1, 6'h00, 6'h10, 6'h3F);
		pixel_source_inst.send(4'h1, 6'h00, 6'h10, 64'h1111);
		pixel_source_inst.send(4'h3, 6'h00, 6'h08, 64'h0080);
		#1;
		judge(64'h1111, 6'h00, 12'h800);
		pixel_source_inst.idle();
		#1;
		judge(64'hFFFF_FFFF_FFFF_FF80, 6'h00, 12'h800);
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		finish_test();
	end

	initial begin
		n_fail = 0;
		n_tests = 0;
		sys_rst = 1'b1;
		test_reset_and_illegal();
		test_int();
		test_scaled();
		test_signed_normalized();
		test_wide_float();
		test_small_float();
		test_shared();
		test_narrow();
		test_back_to_back();
		finish_test();
	end
endmodule
